// ===== core/sll_cfg.svh
// Register offsets, reset values and timing constants of the status light block
`ifndef SLL_CFG_SVH
`define SLL_CFG_SVH

// ----------------------------------------------------------------
// Holding register numbers
// ----------------------------------------------------------------
`define SLL_HR_COMM_TIMEOUT 16'h0008
`define SLL_HR_BUS_TERM 16'h0009
`define SLL_HR_LIGHT_ACTIVE 16'h0023
`define SLL_HR_LIGHT_STANDBY 16'h0024
`define SLL_HR_LED_SOURCE 16'h004f
`define SLL_HR_LED_BRIGHT 16'h0050

// ----------------------------------------------------------------
// Input register numbers
// ----------------------------------------------------------------
`define SLL_IR_LIGHT_LUX 16'h0029
`define SLL_IR_LIGHT_CLASS 16'h002a

// ----------------------------------------------------------------
// Reset values and field codes
// ----------------------------------------------------------------
`define SLL_RST_COMM_TIMEOUT 16'h0000
`define SLL_RST_BUS_TERM 16'h0000
`define SLL_RST_LIGHT_ACTIVE 16'h01f4
`define SLL_RST_LIGHT_STANDBY 16'h0064
`define SLL_RST_LED_SOURCE 16'h0000
`define SLL_RST_LED_BRIGHT 16'h0064
`define SLL_SRC_HUMIDITY_BIT 0
`define SLL_BRIGHT_FULL_PCT 16'h0064
`define SLL_BRIGHT_STEP_PCT 16'h000a
`define SLL_BRIGHT_STEPS 10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SLL_CLK_MHZ 100
`define SLL_BLINK_HALF_US 500000
`define SLL_SECOND_US 1000000
`define SLL_PWM_STEP_US 100
`define SLL_BLINK_HALF_CYC (`SLL_BLINK_HALF_US * `SLL_CLK_MHZ)
`define SLL_SECOND_CYC (`SLL_SECOND_US * `SLL_CLK_MHZ)
`define SLL_PWM_STEP_CYC (`SLL_PWM_STEP_US * `SLL_CLK_MHZ)

`endif

// ===== core/sll_pkg.sv
// Types shared by the status light block
`include "sll_cfg.svh"

package sll_pkg;

  // Light classification, codes as reported in the class register
  typedef enum logic [1:0] {SLL_STANDBY, SLL_LOW_INTENSITY, SLL_ACTIVE} sll_light_t;

  // Which indicator pattern currently governs the lights
  typedef enum logic [1:0] {SLL_M_BOOT, SLL_M_OFF, SLL_M_FAULT, SLL_M_RANGE} sll_mode_t;

  typedef struct packed {
    logic signed [15:0] alertMin;
    logic signed [15:0] alertMax;
    logic signed [15:0] rangeMin;
    logic signed [15:0] rangeMax;
  } sll_limits_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic inputSpace;
    logic [15:0] addr;
    logic [15:0] data;
  } sll_reg_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] data;
  } sll_reg_rsp_t;

  typedef struct packed {
    logic green;
    logic yellow;
    logic red;
  } sll_leds_t;

endpackage

// ===== core/sll_pwm.sv
// Brightness modulator for the indicator lights
`timescale 1ns/1ps
`include "sll_cfg.svh"

module sll_pwm
  import sll_pkg::*;
#(
  parameter int STEPS = `SLL_BRIGHT_STEPS,
  parameter int STEP_CYCLES = `SLL_PWM_STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] level,
  output logic pwmOn
);

  logic [31:0] preCnt_ff;
  logic [31:0] nxt_preCnt;
  logic [3:0] stepCnt_ff;
  logic [3:0] nxt_stepCnt;
  logic pwmOn_ff;
  logic nxt_pwmOn;

  // ----------------------------------------------------------------
  // Step counter: one frame is STEPS slots of STEP_CYCLES each
  // ----------------------------------------------------------------
  always_comb begin
    nxt_preCnt = preCnt_ff + 32'h00000001;
    nxt_stepCnt = stepCnt_ff;
    if (preCnt_ff >= 32'(STEP_CYCLES - 1)) begin
      nxt_preCnt = 32'h00000000;
      if (stepCnt_ff >= 4'(STEPS - 1)) begin
        nxt_stepCnt = 4'h0;
      end else begin
        nxt_stepCnt = stepCnt_ff + 4'h1;
      end
    end
    // Level 0 never lights, level STEPS lights every slot
    nxt_pwmOn = stepCnt_ff < level;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      preCnt_ff <= 32'h00000000;
      stepCnt_ff <= 4'h0;
      pwmOn_ff <= 1'b0;
    end else begin
      preCnt_ff <= nxt_preCnt;
      stepCnt_ff <= nxt_stepCnt;
      pwmOn_ff <= nxt_pwmOn;
    end
  end

  assign pwmOn = pwmOn_ff;

endmodule

// ===== core/status_led_light_level.sv
// Status indicator lights and ambient light classification
//
// Overview of operation
// R1 - Green steady inside alert limits
// R2 - Yellow steady outside alert limits, inside measurement range
// R3 - Yellow blinks on bus timeout, timeout nonzero
// R4 - Red steady outside measurement range
// R5 - Red blinks on sensing element link loss
// R6 - Bootloader: green and yellow alternate
// R7 - Download: red flashes as well
// R8 - Source temperature, humidity when selected
// R9 - Brightness zero to full, tenth steps
// R10 - Brightness zero switches all lights off
// R11 - Lux reading readable as input register
// R12 - Active and standby thresholds are writable
// R13 - Below standby threshold reports standby
// R14 - Above active threshold reports active
// R15 - Between thresholds reports low intensity
// R16 - Termination resistor follows enable register
// R17 - Network sets termination in two devices
// R18 - Priority: boot, off, faults, range
// R19 - Reading equal to threshold is low
`timescale 1ns/1ps
`include "sll_cfg.svh"

module status_led_light_level
  import sll_pkg::*;
#(
  parameter int BLINK_HALF_CYCLES = `SLL_BLINK_HALF_CYC,
  parameter int SECOND_CYCLES = `SLL_SECOND_CYC,
  parameter int PWM_STEP_CYCLES = `SLL_PWM_STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire sll_reg_req_t regReq,
  output sll_reg_rsp_t regRsp,
  input wire logic commFrame,
  input wire logic signed [15:0] temperatureValue,
  input wire logic signed [15:0] relative_humidity_value,
  input wire sll_limits_t tempLimits,
  input wire sll_limits_t humLimits,
  input wire logic sensorLinkLost,
  input wire logic bootMode,
  input wire logic bootDownload,
  input wire logic [15:0] luxValue,
  output sll_leds_t leds,
  output logic bus_termination_resistor
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic sll_leds_t rangeLeds(input logic signed [15:0] v,
                                          input sll_limits_t lim);
    sll_leds_t r;
    r = '0;
    if (v < lim.rangeMin || v > lim.rangeMax) begin
      r.red = 1'b1; // see R4
    end else if (v >= lim.alertMin && v <= lim.alertMax) begin
      r.green = 1'b1; // see R1
    end else begin
      r.yellow = 1'b1; // see R2
    end
    return r;
  endfunction

  // Percent to tenths, anything above full scale counts as full
  function automatic logic [3:0] brightSteps(input logic [15:0] pct);
    logic [15:0] q;
    q = pct / `SLL_BRIGHT_STEP_PCT;
    if (pct >= `SLL_BRIGHT_FULL_PCT) begin
      q = 16'(`SLL_BRIGHT_STEPS);
    end
    return q[3:0]; // see R9
  endfunction

  function automatic sll_light_t classify(input logic [15:0] lux,
                                          input logic [15:0] standby,
                                          input logic [15:0] active);
    sll_light_t c;
    if (lux < standby) begin
      c = SLL_STANDBY; // see R13
    end else if (lux > active) begin
      c = SLL_ACTIVE; // see R14
    end else begin
      // Equal to either level falls here as well
      c = SLL_LOW_INTENSITY; // see R15, see R19
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Holding registers and read port
  // ----------------------------------------------------------------
  logic [15:0] timeout_ff, nxt_timeout;
  logic [15:0] busTerm_ff, nxt_busTerm;
  logic [15:0] activeThr_ff, nxt_activeThr;
  logic [15:0] standbyThr_ff, nxt_standbyThr;
  logic [15:0] ledSource_ff, nxt_ledSource;
  logic [15:0] bright_ff, nxt_bright;
  logic [15:0] lux_ff, nxt_lux;
  sll_light_t lightClass_ff, nxt_lightClass;
  sll_reg_rsp_t rsp_ff, nxt_rsp;
  logic busTermOut_ff, nxt_busTermOut;

  always_comb begin
    nxt_timeout = timeout_ff;
    nxt_busTerm = busTerm_ff;
    nxt_activeThr = activeThr_ff;
    nxt_standbyThr = standbyThr_ff;
    nxt_ledSource = ledSource_ff;
    nxt_bright = bright_ff;
    nxt_rsp = '0;
    nxt_lux = luxValue; // see R11
    nxt_lightClass = classify(lux_ff, standbyThr_ff, activeThr_ff);
    nxt_busTermOut = busTerm_ff != 16'h0000; // see R16
    if (regReq.wr) begin
      nxt_rsp.valid = 1'b1;
      if (regReq.inputSpace) begin
        // Input registers are read only
        nxt_rsp.err = 1'b1;
      end else begin
        case (regReq.addr)
          `SLL_HR_COMM_TIMEOUT: nxt_timeout = regReq.data;
          `SLL_HR_BUS_TERM: nxt_busTerm = regReq.data;
          `SLL_HR_LIGHT_ACTIVE: nxt_activeThr = regReq.data; // see R12
          `SLL_HR_LIGHT_STANDBY: nxt_standbyThr = regReq.data; // see R12
          `SLL_HR_LED_SOURCE: nxt_ledSource = regReq.data;
          `SLL_HR_LED_BRIGHT: nxt_bright = regReq.data;
          default: nxt_rsp.err = 1'b1;
        endcase
      end
    end else if (regReq.rd) begin
      nxt_rsp.valid = 1'b1;
      if (regReq.inputSpace) begin
        case (regReq.addr)
          `SLL_IR_LIGHT_LUX: nxt_rsp.data = lux_ff; // see R11
          `SLL_IR_LIGHT_CLASS: nxt_rsp.data = {14'h0000, lightClass_ff};
          default: nxt_rsp.err = 1'b1;
        endcase
      end else begin
        case (regReq.addr)
          `SLL_HR_COMM_TIMEOUT: nxt_rsp.data = timeout_ff;
          `SLL_HR_BUS_TERM: nxt_rsp.data = busTerm_ff;
          `SLL_HR_LIGHT_ACTIVE: nxt_rsp.data = activeThr_ff;
          `SLL_HR_LIGHT_STANDBY: nxt_rsp.data = standbyThr_ff;
          `SLL_HR_LED_SOURCE: nxt_rsp.data = ledSource_ff;
          `SLL_HR_LED_BRIGHT: nxt_rsp.data = bright_ff;
          default: nxt_rsp.err = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      timeout_ff <= `SLL_RST_COMM_TIMEOUT;
      busTerm_ff <= `SLL_RST_BUS_TERM;
      activeThr_ff <= `SLL_RST_LIGHT_ACTIVE;
      standbyThr_ff <= `SLL_RST_LIGHT_STANDBY;
      ledSource_ff <= `SLL_RST_LED_SOURCE;
      bright_ff <= `SLL_RST_LED_BRIGHT;
      lux_ff <= 16'h0000;
      lightClass_ff <= SLL_STANDBY;
      rsp_ff <= '0;
      busTermOut_ff <= 1'b0;
    end else begin
      timeout_ff <= nxt_timeout;
      busTerm_ff <= nxt_busTerm;
      activeThr_ff <= nxt_activeThr;
      standbyThr_ff <= nxt_standbyThr;
      ledSource_ff <= nxt_ledSource;
      bright_ff <= nxt_bright;
      lux_ff <= nxt_lux;
      lightClass_ff <= nxt_lightClass;
      rsp_ff <= nxt_rsp;
      busTermOut_ff <= nxt_busTermOut;
    end
  end

  // ----------------------------------------------------------------
  // Blink time base and bus silence timer
  // ----------------------------------------------------------------
  logic [31:0] blinkCnt_ff, nxt_blinkCnt;
  logic blinkPhase_ff, nxt_blinkPhase;
  logic [31:0] secCnt_ff, nxt_secCnt;
  logic [15:0] idleSec_ff, nxt_idleSec;

  always_comb begin
    nxt_blinkCnt = blinkCnt_ff + 32'h00000001;
    nxt_blinkPhase = blinkPhase_ff;
    if (blinkCnt_ff >= 32'(BLINK_HALF_CYCLES - 1)) begin
      nxt_blinkCnt = 32'h00000000;
      nxt_blinkPhase = ~blinkPhase_ff;
    end
    nxt_secCnt = secCnt_ff + 32'h00000001;
    nxt_idleSec = idleSec_ff;
    if (secCnt_ff >= 32'(SECOND_CYCLES - 1)) begin
      nxt_secCnt = 32'h00000000;
      // Saturates so a long silence never wraps back to healthy
      if (idleSec_ff != 16'hffff) begin
        nxt_idleSec = idleSec_ff + 16'h0001;
      end
    end
    // Any frame on the bus restarts the silence measurement
    if (commFrame) begin
      nxt_secCnt = 32'h00000000;
      nxt_idleSec = 16'h0000;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      blinkCnt_ff <= 32'h00000000;
      blinkPhase_ff <= 1'b0;
      secCnt_ff <= 32'h00000000;
      idleSec_ff <= 16'h0000;
    end else begin
      blinkCnt_ff <= nxt_blinkCnt;
      blinkPhase_ff <= nxt_blinkPhase;
      secCnt_ff <= nxt_secCnt;
      idleSec_ff <= nxt_idleSec;
    end
  end

  // ----------------------------------------------------------------
  // Indicator pattern selection
  // ----------------------------------------------------------------
  logic pwmOn;
  logic commTimedOut;
  sll_mode_t mode;
  sll_leds_t pattern;
  sll_leds_t leds_ff, nxt_leds;

  sll_pwm #(
    .STEPS(`SLL_BRIGHT_STEPS),
    .STEP_CYCLES(PWM_STEP_CYCLES)
  ) u_pwm (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .level(brightSteps(bright_ff)),
    .pwmOn(pwmOn)
  );

  // A zero timeout disables the supervision
  assign commTimedOut = (timeout_ff != 16'h0000) && (idleSec_ff >= timeout_ff); // see R3

  always_comb begin
    if (bootMode) begin
      mode = SLL_M_BOOT; // see R18
    end else if (bright_ff == 16'h0000) begin
      mode = SLL_M_OFF;
    end else if (commTimedOut || sensorLinkLost) begin
      mode = SLL_M_FAULT;
    end else begin
      mode = SLL_M_RANGE;
    end
    pattern = '0;
    case (mode)
      SLL_M_BOOT: begin
        pattern.green = blinkPhase_ff; // see R6
        pattern.yellow = ~blinkPhase_ff; // see R6
        pattern.red = bootDownload & blinkPhase_ff; // see R7
      end
      SLL_M_OFF: begin
        pattern = '0; // see R10
      end
      SLL_M_FAULT: begin
        pattern.yellow = commTimedOut & blinkPhase_ff; // see R3
        pattern.red = sensorLinkLost & blinkPhase_ff; // see R5
      end
      SLL_M_RANGE: begin
        if (ledSource_ff[`SLL_SRC_HUMIDITY_BIT]) begin
          pattern = rangeLeds(relative_humidity_value, humLimits); // see R8
        end else begin
          pattern = rangeLeds(temperatureValue, tempLimits); // see R8
        end
      end
      default: pattern = '0;
    endcase
    // Dimming gates every lamp; zero brightness also forces zero steps
    nxt_leds.green = pattern.green & pwmOn; // see R9
    nxt_leds.yellow = pattern.yellow & pwmOn;
    nxt_leds.red = pattern.red & pwmOn;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      leds_ff <= '0;
    end else begin
      leds_ff <= nxt_leds;
    end
  end

  assign leds = leds_ff;
  assign regRsp = rsp_ff;
  assign bus_termination_resistor = busTermOut_ff;

endmodule

// ===== testbench/sll_chk.sv
// Assertion checker for the status light block
`timescale 1ns/1ps

module sll_chk
  import sll_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire sll_reg_req_t regReq,
  input wire sll_reg_rsp_t regRsp,
  input wire logic sensorLinkLost,
  input wire logic bootMode,
  input wire logic bootDownload,
  input wire sll_leds_t leds,
  input wire logic bus_termination_resistor
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Request shapes
  // ----------------------------------------------------------------
  sequence hold_wr(logic [15:0] a);
    regReq.wr && !regReq.inputSpace && regReq.addr == a;
  endsequence
  sequence plain_rd(logic isp, logic [15:0] a);
    regReq.rd && !regReq.wr && regReq.inputSpace == isp && regReq.addr == a;
  endsequence

  rsp_answer_a: assert property ((regReq.wr || regReq.rd) |=> regRsp.valid)
    else $error("request not answered next cycle");
  rsp_quiet_a: assert property (!(regReq.wr || regReq.rd) |=> !regRsp.valid)
    else $error("answer without request");
  ro_write_a: assert property (regReq.wr && regReq.inputSpace |=> regRsp.valid && regRsp.err)
    else $error("write to input table not refused");
  unmapped_read_a: assert property (plain_rd(1'b0, 16'h0000) |=> regRsp.err && regRsp.data == 16'h0000)
    else $error("unmapped read not refused");
  class_code_a: assert property (plain_rd(1'b1, 16'h002a) |=> !regRsp.err && regRsp.data[15:2] == 14'h0000 && regRsp.data[1:0] != 2'h3)
    else $error("class code out of set");
  term_on_a: assert property (hold_wr(16'h0009) ##0 regReq.data != 16'h0000 |-> ##2 bus_termination_resistor)
    else $error("termination not connected");
  term_off_a: assert property (hold_wr(16'h0009) ##0 regReq.data == 16'h0000 |-> ##2 !bus_termination_resistor)
    else $error("termination not released");
  green_yellow_a: assert property (!(leds.green && leds.yellow))
    else $error("green and yellow lit together");
  link_green_a: assert property ($past(sensorLinkLost) && !$past(bootMode) |-> !leds.green)
    else $error("green lit during link fault");
  boot_red_a: assert property ($past(bootMode) && !$past(bootDownload) |-> !leds.red)
    else $error("red lit in boot without download");
endmodule

bind status_led_light_level sll_chk chk(.sys_clk(sys_clk), .resetn(resetn), .regReq(regReq),
  .regRsp(regRsp), .sensorLinkLost(sensorLinkLost), .bootMode(bootMode),
  .bootDownload(bootDownload), .leds(leds), .bus_termination_resistor(bus_termination_resistor));

// ===== testbench/sll_master.sv
// Register bus master model facing the status light block
`timescale 1ns/1ps

module sll_master
  import sll_pkg::*;
(
  input wire logic sys_clk,
  output sll_reg_req_t regReq,
  input wire sll_reg_rsp_t regRsp
);
  initial regReq = '0;

  // One request per call: taken and answered on one rising edge, read at the falling edge after it
  task automatic xfer(input logic wr, input logic isp, input logic [15:0] a,
      input logic [15:0] d, output sll_reg_rsp_t rsp);
    @(negedge sys_clk);
    regReq = '{wr: wr, rd: !wr, inputSpace: isp, addr: a, data: d};
    @(negedge sys_clk);
    // The answer stands for one cycle only, so take it before moving on
    rsp = regRsp;
    // Released fields carry the inverse so a stale value never looks live
    regReq = '{wr: 1'b0, rd: 1'b0, inputSpace: !isp, addr: ~a, data: ~d};
    @(negedge sys_clk);
  endtask
endmodule

// ===== testbench/tb_top.sv
// Self-checking testbench for the status light block
`timescale 1ns/1ps

module tb_top;
  import sll_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  sll_reg_req_t regReq;
  sll_reg_rsp_t regRsp;
  logic commFrame = 1'b0;
  logic keepAlive = 1'b1;
  logic signed [15:0] temp = 16'h0014;
  logic signed [15:0] hum = 16'h0000;
  sll_limits_t tLim = '{16'h000a, 16'h001e, 16'h0000, 16'h0032};
  sll_limits_t hLim = '{16'h0028, 16'h003c, 16'h0000, 16'h0064};
  logic linkLost = 1'b0;
  logic boot = 1'b0;
  logic dl = 1'b0;
  logic [15:0] lux = 16'h0000;
  sll_leds_t leds;
  logic term;
  int fail_count = 0;
  int checks_done = 0;
  int tick = 0;
  int g, y, r, b;
  logic [15:0] ha[6] = '{16'h0008, 16'h0009, 16'h0023, 16'h0024, 16'h004f, 16'h0050};
  logic [15:0] hv[6] = '{16'h0000, 16'h0000, 16'h01f4, 16'h0064, 16'h0000, 16'h0064};
  logic [15:0] lx[5] = '{16'h0032, 16'h0064, 16'h00fa, 16'h0190, 16'h0191};
  logic [15:0] lc[5] = '{16'h0000, 16'h0001, 16'h0001, 16'h0001, 16'h0002};
  logic [15:0] tv[5] = '{16'h0014, 16'h000a, 16'h0028, 16'h003c, 16'hfffb};
  logic [2:0] te[5] = '{3'h4, 3'h4, 3'h2, 3'h1, 3'h1};

  always #5 sys_clk = ~sys_clk;

  // Keep-alive frames every ten cycles, well inside one shortened second
  always @(negedge sys_clk) begin
    tick <= tick + 1;
    commFrame <= keepAlive && (tick % 10 == 0);
  end

  status_led_light_level #(.BLINK_HALF_CYCLES(8), .SECOND_CYCLES(20), .PWM_STEP_CYCLES(1)) dut(
    .sys_clk(sys_clk), .resetn(resetn), .regReq(regReq), .regRsp(regRsp),
    .commFrame(commFrame), .temperatureValue(temp), .relative_humidity_value(hum),
    .tempLimits(tLim), .humLimits(hLim), .sensorLinkLost(linkLost), .bootMode(boot),
    .bootDownload(dl), .luxValue(lux), .leds(leds), .bus_termination_resistor(term));

  sll_master master(.sys_clk(sys_clk), .regReq(regReq), .regRsp(regRsp));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rw(input logic wr, input logic isp, input logic [15:0] a, input logic [15:0] d,
      input logic [15:0] exp, input logic experr);
    sll_reg_rsp_t rsp;
    master.xfer(wr, isp, a, d, rsp);
    check({15'h0000, rsp.valid}, 16'h0001);
    check({15'h0000, rsp.err}, {15'h0000, experr});
    if (!wr) check(rsp.data, exp);
  endtask

  // Counts lamp-on cycles; b counts cycles with green and yellow together
  task automatic watch(input int n);
    g = 0;
    y = 0;
    r = 0;
    b = 0;
    repeat (n) begin
      @(negedge sys_clk);
      g += int'(leds.green === 1'b1);
      y += int'(leds.yellow === 1'b1);
      r += int'(leds.red === 1'b1);
      b += int'(leds.green === 1'b1 && leds.yellow === 1'b1);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge sys_clk);
    resetn = 1'b1;
    for (int i = 0; i < 6; i++) rw(1'b0, 1'b0, ha[i], 16'h0000, hv[i], 1'b0);
    rw(1'b0, 1'b1, 16'h002a, 16'h0000, 16'h0000, 1'b0);
    rw(1'b1, 1'b0, 16'h0023, 16'h0190, 16'h0000, 1'b0);
    rw(1'b0, 1'b0, 16'h0023, 16'h0000, 16'h0190, 1'b0);
    rw(1'b1, 1'b1, 16'h0029, 16'h1234, 16'h0000, 1'b1);
    rw(1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b1);
    rw(1'b0, 1'b1, 16'h0008, 16'h0000, 16'h0000, 1'b1);
    for (int i = 0; i < 5; i++) begin
      lux = lx[i];
      repeat (3) @(negedge sys_clk);
      rw(1'b0, 1'b1, 16'h0029, 16'h0000, lx[i], 1'b0);
      rw(1'b0, 1'b1, 16'h002a, 16'h0000, lc[i], 1'b0);
    end
    rw(1'b1, 1'b0, 16'h0009, 16'h0001, 16'h0000, 1'b0);
    repeat (3) @(negedge sys_clk);
    check({15'h0000, term}, 16'h0001);
    rw(1'b1, 1'b0, 16'h0009, 16'h0000, 16'h0000, 1'b0);
    repeat (3) @(negedge sys_clk);
    check({15'h0000, term}, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      temp = tv[i];
      repeat (3) @(negedge sys_clk);
      watch(10);
      check(16'(g + 2 * y + 4 * r), 16'(te[i][2] * 10 + te[i][1] * 20 + te[i][0] * 40));
    end
    rw(1'b1, 1'b0, 16'h004f, 16'h0001, 16'h0000, 1'b0);
    hum = 16'h0032;
    repeat (3) @(negedge sys_clk);
    watch(10);
    check(16'(g + 2 * y + 4 * r), 16'h000a);
    rw(1'b1, 1'b0, 16'h0050, 16'h0032, 16'h0000, 1'b0);
    watch(20);
    check(16'(g), 16'h000a);
    rw(1'b1, 1'b0, 16'h0050, 16'h0000, 16'h0000, 1'b0);
    linkLost = 1'b1;
    watch(32);
    check(16'(g + y + r), 16'h0000);
    rw(1'b1, 1'b0, 16'h0050, 16'h0064, 16'h0000, 1'b0);
    watch(32);
    check(16'(g + 2 * y + 4 * r), 16'h0040);
    linkLost = 1'b0;
    rw(1'b1, 1'b0, 16'h0008, 16'h0001, 16'h0000, 1'b0);
    watch(32);
    check(16'(g + 2 * y), 16'h0020);
    keepAlive = 1'b0;
    repeat (40) @(negedge sys_clk);
    watch(32);
    check(16'(g + 2 * y + 4 * r), 16'h0020);
    keepAlive = 1'b1;
    repeat (30) @(negedge sys_clk);
    boot = 1'b1;
    repeat (3) @(negedge sys_clk);
    watch(32);
    check(16'(g + 2 * y + 4 * r + 8 * b), 16'h0030);
    dl = 1'b1;
    watch(32);
    check(16'(r), 16'h0010);
    boot = 1'b0;
    dl = 1'b0;
    final_report();
  end
endmodule
